// ---- core/config_space.sv ----
// indexed configuration space with general-purpose port and watchdog
//
// Summary of operation
// - direction bit one makes pin input, zero output; resets to all ones
// - output pins: value bit is written and read back; value resets zero
// - input pins: value bit read only, host writes to it are dropped
// - polarity bit one inverts pin value in and out; resets to zero
// - index port is write only, at 2Eh or 4Eh by strap
// - data port is read/write at 2Fh or 4Fh, reaches indexed register
// - two successive 87h index writes unlock configuration access
// - AAh to index port relocks; data accesses ignored until unlocked
// - index 0x07 picks logical device: 0x07 port, 0x08 watchdog
// - index 0x30 activates the selected device: 0x01 on, 0x00 off
// - watchdog index 0xF5 picks unit; 0x00 counts seconds
// - watchdog index F6h holds the timeout count in that unit
// - watchdog expiry resets the cpu or raises an interrupt
// - index 0x2A is pin function mux; host sets all eight bits 7..0
// - port device: direction F0h, value F1h, polarity F2h
`timescale 1ns/100ps
`default_nettype none
module config_space
#(
   parameter int PINS = 8,
   parameter int SECOND_CYCLES = cfg_pkg::SECOND_CYCLES,
   parameter int RESET_CYCLES = cfg_pkg::RESET_PULSE_CYCLES
)
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic reset_in,
   // host i/o port access
   input wire logic [15:0] io_addr_in,
   input wire logic io_wr_in,
   input wire logic io_rd_in,
   input wire logic [7:0] io_wdata_in,
   output logic [7:0] io_rdata_out,
   output logic io_rvalid_out,
   // board strap: high places the ports at 4Eh/4Fh
   input wire logic port_strap_in,
   // general-purpose pins
   input wire logic [PINS-1:0] gpio_pin_in,
   output logic [PINS-1:0] gpio_pin_out,
   output logic [PINS-1:0] gpio_pin_oe_out,
   // watchdog
   input wire logic wdt_irq_mode_in,
   output logic cpu_reset_out,
   output logic wdt_irq_out,
   // status
   output logic config_unlocked_out
);
   typedef struct packed {
      cfg_pkg::lock_state_t lock;
      logic strap_done;
      logic strap_alt;
      logic [7:0] index;
      logic [7:0] ldn;
      logic [7:0] pin_mux;
      logic gpio_active;
      logic wdt_active;
      logic [PINS-1:0] dir;
      logic [PINS-1:0] value;
      logic [PINS-1:0] pol;
      logic [7:0] wdt_unit;
      logic [7:0] rdata;
      logic rvalid;
      logic [PINS-1:0] pin_out;
      logic [PINS-1:0] pin_oe;
      logic unlocked;
   } state_t;
   state_t s;
   state_t next_s;
   logic hit_index;
   logic hit_data;
   logic data_wr;
   logic data_rd;
   logic sel_gpio;
   logic sel_wdt;
   logic value_wr;
   logic wdt_load;
   logic [7:0] wdt_count;
   logic [PINS-1:0] bit_read;
   logic [PINS-1:0] bit_next_value;
   logic [PINS-1:0] bit_drive;
   logic [PINS-1:0] bit_oe;
   logic [7:0] read_mux;
   // ==========================================================
   // address decode
   always_comb
   begin
      hit_index = s.strap_alt ? (io_addr_in == cfg_pkg::INDEX_PORT_HI)
                              : (io_addr_in == cfg_pkg::INDEX_PORT_LO);
      hit_data = s.strap_alt ? (io_addr_in == cfg_pkg::DATA_PORT_HI)
                             : (io_addr_in == cfg_pkg::DATA_PORT_LO);
      // locked space swallows data accesses without side effects
      data_wr = hit_data && io_wr_in && (s.lock == cfg_pkg::UNLOCKED);
      data_rd = hit_data && io_rd_in && (s.lock == cfg_pkg::UNLOCKED);
      sel_gpio = (s.ldn == cfg_pkg::LDN_GPIO);
      sel_wdt = (s.ldn == cfg_pkg::LDN_WDT);
      value_wr = data_wr && sel_gpio && (s.index == cfg_pkg::IDX_VALUE);
      wdt_load = data_wr && sel_wdt && (s.index == cfg_pkg::IDX_WDT_COUNT);
   end
   // ==========================================================
   // per-pin logic
   genvar gi;
   generate
      for (gi = 0; gi < PINS; gi++)
      begin : g_pin
         gpio_bit u_bit
         (
            .dir_in(s.dir[gi]),
            .value_in(s.value[gi]),
            .pol_in(s.pol[gi]),
            .enable_in(s.gpio_active),
            .wr_in(value_wr),
            .wdata_in(io_wdata_in[gi]),
            .pin_in(gpio_pin_in[gi]),
            .read_out(bit_read[gi]),
            .next_value_out(bit_next_value[gi]),
            .drive_out(bit_drive[gi]),
            .oe_out(bit_oe[gi])
         );
      end
   endgenerate
   // ==========================================================
   // watchdog
   watchdog_timer
   #(
      .SECOND_CYCLES(SECOND_CYCLES),
      .RESET_CYCLES(RESET_CYCLES)
   )
   u_wdt
   (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .active_in(s.wdt_active),
      .load_in(wdt_load),
      .load_count_in(io_wdata_in),
      .unit_in(s.wdt_unit),
      .irq_mode_in(wdt_irq_mode_in),
      .count_out(wdt_count),
      .cpu_reset_out(cpu_reset_out),
      .irq_out(wdt_irq_out)
   );
   // ==========================================================
   // read multiplexer
   always_comb
   begin
      read_mux = 8'h00;
      unique case (s.index)
         cfg_pkg::IDX_LDN: read_mux = s.ldn;
         cfg_pkg::IDX_PIN_MUX: read_mux = s.pin_mux;
         cfg_pkg::IDX_ACTIVATE:
         begin
            if (sel_gpio)
            begin
               read_mux[cfg_pkg::ACT_BIT] = s.gpio_active;
            end
            else if (sel_wdt)
            begin
               read_mux[cfg_pkg::ACT_BIT] = s.wdt_active;
            end
         end
         cfg_pkg::IDX_DIR: read_mux = sel_gpio ? 8'(s.dir) : 8'h00;
         cfg_pkg::IDX_VALUE: read_mux = sel_gpio ? 8'(bit_read) : 8'h00;
         cfg_pkg::IDX_POL: read_mux = sel_gpio ? 8'(s.pol) : 8'h00;
         cfg_pkg::IDX_WDT_UNIT: read_mux = sel_wdt ? s.wdt_unit : 8'h00;
         cfg_pkg::IDX_WDT_COUNT: read_mux = sel_wdt ? wdt_count : 8'h00;
         default: read_mux = 8'h00;
      endcase
   end
   // ==========================================================
   // next state
   always_comb
   begin
      next_s = s;
      // strap is sampled once, on the first edge after reset release
      if (!s.strap_done)
      begin
         next_s.strap_done = 1'b1;
         next_s.strap_alt = port_strap_in;
      end
      if (hit_index && io_wr_in)
      begin
         unique case (s.lock)
            cfg_pkg::LOCKED:
            begin
               if (io_wdata_in == cfg_pkg::UNLOCK_KEY)
               begin
                  next_s.lock = cfg_pkg::KEY_ONCE;
               end
            end
            cfg_pkg::KEY_ONCE:
            begin
               // any other value breaks the pair, so both keys must be adjacent
               next_s.lock = (io_wdata_in == cfg_pkg::UNLOCK_KEY) ? cfg_pkg::UNLOCKED
                                                                 : cfg_pkg::LOCKED;
            end
            cfg_pkg::UNLOCKED:
            begin
               if (io_wdata_in == cfg_pkg::LOCK_KEY)
               begin
                  next_s.lock = cfg_pkg::LOCKED;
               end
               else
               begin
                  next_s.index = io_wdata_in;
               end
            end
            default: next_s.lock = cfg_pkg::LOCKED;
         endcase
      end
      if (data_wr)
      begin
         unique case (s.index)
            cfg_pkg::IDX_LDN: next_s.ldn = io_wdata_in;
            cfg_pkg::IDX_PIN_MUX: next_s.pin_mux = io_wdata_in;
            cfg_pkg::IDX_ACTIVATE:
            begin
               if (sel_gpio)
               begin
                  next_s.gpio_active = io_wdata_in[cfg_pkg::ACT_BIT];
               end
               else if (sel_wdt)
               begin
                  next_s.wdt_active = io_wdata_in[cfg_pkg::ACT_BIT];
               end
            end
            cfg_pkg::IDX_DIR:
            begin
               if (sel_gpio)
               begin
                  next_s.dir = io_wdata_in[PINS-1:0];
               end
            end
            cfg_pkg::IDX_POL:
            begin
               if (sel_gpio)
               begin
                  next_s.pol = io_wdata_in[PINS-1:0];
               end
            end
            cfg_pkg::IDX_WDT_UNIT:
            begin
               if (sel_wdt)
               begin
                  next_s.wdt_unit = io_wdata_in;
               end
            end
            default:
            begin
            end
         endcase
      end
      next_s.value = bit_next_value;
      // pins follow the registers one cycle later to keep outputs on flops
      next_s.pin_out = bit_drive;
      next_s.pin_oe = bit_oe;
      // reads of the index port or of a locked space answer with all ones
      next_s.rvalid = (hit_index || hit_data) && io_rd_in;
      next_s.rdata = data_rd ? read_mux : cfg_pkg::IDLE_READ;
      next_s.unlocked = (next_s.lock == cfg_pkg::UNLOCKED);
   end
   // ==========================================================
   // state register
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         s <= '{lock: cfg_pkg::LOCKED, strap_done: 1'b0, strap_alt: 1'b0,
                index: cfg_pkg::INDEX_RESET, ldn: cfg_pkg::LDN_RESET,
                pin_mux: cfg_pkg::PIN_MUX_RESET, gpio_active: 1'b0, wdt_active: 1'b0,
                dir: cfg_pkg::DIR_RESET[PINS-1:0], value: cfg_pkg::VALUE_RESET[PINS-1:0],
                pol: cfg_pkg::POL_RESET[PINS-1:0], wdt_unit: cfg_pkg::WDT_UNIT_RESET,
                rdata: 8'h00, rvalid: 1'b0, pin_out: '0, pin_oe: '0, unlocked: 1'b0};
      end
      else
      begin
         s <= next_s;
      end
   end
   // ==========================================================
   // outputs
   assign io_rdata_out = s.rdata;
   assign io_rvalid_out = s.rvalid;
   assign gpio_pin_out = s.pin_out;
   assign gpio_pin_oe_out = s.pin_oe;
   assign config_unlocked_out = s.unlocked;
endmodule
`default_nettype wire

// ---- core/gpio_bit.sv ----
// one general-purpose pin: direction, data and inversion handling
`timescale 1ns/100ps
`default_nettype none
module gpio_bit
(
   // configuration bits
   input wire logic dir_in,
   input wire logic value_in,
   input wire logic pol_in,
   input wire logic enable_in,
   // host write of the value register
   input wire logic wr_in,
   input wire logic wdata_in,
   // pin
   input wire logic pin_in,
   output logic read_out,
   output logic next_value_out,
   output logic drive_out,
   output logic oe_out
);
   // ==========================================================
   // read path and write masking
   always_comb
   begin
      read_out = dir_in ? (pin_in ^ pol_in) : value_in;
      next_value_out = (wr_in && !dir_in) ? wdata_in : value_in;
      drive_out = value_in ^ pol_in;
      oe_out = !dir_in && enable_in;
   end
endmodule
`default_nettype wire

// ---- core/watchdog_timer.sv ----
// watchdog counter with seconds or minutes unit and expiry action
`timescale 1ns/100ps
`default_nettype none
module watchdog_timer
#(
   parameter int SECOND_CYCLES = cfg_pkg::SECOND_CYCLES,
   parameter int RESET_CYCLES = cfg_pkg::RESET_PULSE_CYCLES
)
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic reset_in,
   // control
   input wire logic active_in,
   input wire logic load_in,
   input wire logic [7:0] load_count_in,
   input wire logic [7:0] unit_in,
   input wire logic irq_mode_in,
   // status and action
   output logic [7:0] count_out,
   output logic cpu_reset_out,
   output logic irq_out
);
   localparam int PW = $clog2(SECOND_CYCLES + 1);
   localparam int RW = $clog2(RESET_CYCLES + 1);
   typedef struct packed {
      logic [PW-1:0] prescale;
      logic [5:0] minute;
      logic [7:0] count;
      logic [RW-1:0] rst_cnt;
      logic reset_pulse;
      logic irq;
   } wdt_state_t;
   wdt_state_t s;
   wdt_state_t next_s;
   logic sec_tick;
   logic unit_tick;
   // ==========================================================
   // counting
   always_comb
   begin
      next_s = s;
      sec_tick = (s.prescale == PW'(SECOND_CYCLES - 1));
      unit_tick = sec_tick && ((unit_in == cfg_pkg::UNIT_SECONDS)
                  || (s.minute == 6'(cfg_pkg::MINUTE_SECONDS - 1)));
      if (!active_in || s.count == 8'h00)
      begin
         next_s.prescale = '0;
         next_s.minute = '0;
      end
      else if (sec_tick)
      begin
         next_s.prescale = '0;
         next_s.minute = unit_tick ? 6'h00 : s.minute + 6'h01;
      end
      else
      begin
         next_s.prescale = s.prescale + PW'(1);
      end
      if (s.rst_cnt != '0)
      begin
         next_s.rst_cnt = s.rst_cnt - RW'(1);
      end
      if (!active_in)
      begin
         next_s.irq = 1'b0;
      end
      if (load_in)
      begin
         next_s.count = load_count_in;
         next_s.prescale = '0;
         next_s.minute = '0;
         next_s.irq = 1'b0;
      end
      else if (active_in && s.count != 8'h00 && unit_tick)
      begin
         next_s.count = s.count - 8'h01;
         if (s.count == 8'h01)
         begin
            if (irq_mode_in)
            begin
               next_s.irq = 1'b1;
            end
            else
            begin
               next_s.rst_cnt = RW'(RESET_CYCLES);
            end
         end
      end
      next_s.reset_pulse = (next_s.rst_cnt != '0);
   end
   // ==========================================================
   // state register
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         s <= '{prescale: '0, minute: 6'h00, count: cfg_pkg::WDT_COUNT_RESET,
                rst_cnt: '0, reset_pulse: 1'b0, irq: 1'b0};
      end
      else
      begin
         s <= next_s;
      end
   end
   assign count_out = s.count;
   assign cpu_reset_out = s.reset_pulse;
   assign irq_out = s.irq;
endmodule
`default_nettype wire

// ---- inc/cfg_pkg.sv ----
// constants, reset values and types shared by the configuration space and watchdog
package cfg_pkg;
   // ==========================================================
   // host i/o port addresses
   localparam logic [15:0] INDEX_PORT_LO = 16'h002E;
   localparam logic [15:0] DATA_PORT_LO = 16'h002F;
   localparam logic [15:0] INDEX_PORT_HI = 16'h004E;
   localparam logic [15:0] DATA_PORT_HI = 16'h004F;
   // ==========================================================
   // lock sequence keys
   localparam logic [7:0] UNLOCK_KEY = 8'h87;
   localparam logic [7:0] LOCK_KEY = 8'hAA;
   // ==========================================================
   // configuration indices
   localparam logic [7:0] IDX_LDN = 8'h07;
   localparam logic [7:0] IDX_PIN_MUX = 8'h2A;
   localparam logic [7:0] IDX_ACTIVATE = 8'h30;
   localparam logic [7:0] IDX_DIR = 8'hF0;
   localparam logic [7:0] IDX_VALUE = 8'hF1;
   localparam logic [7:0] IDX_POL = 8'hF2;
   localparam logic [7:0] IDX_WDT_UNIT = 8'hF5;
   localparam logic [7:0] IDX_WDT_COUNT = 8'hF6;
   // ==========================================================
   // logical device numbers and fields
   localparam logic [7:0] LDN_GPIO = 8'h07;
   localparam logic [7:0] LDN_WDT = 8'h08;
   localparam int ACT_BIT = 0;
   localparam logic [7:0] UNIT_SECONDS = 8'h00;
   // ==========================================================
   // reset values
   localparam logic [7:0] DIR_RESET = 8'hFF;
   localparam logic [7:0] VALUE_RESET = 8'h00;
   localparam logic [7:0] POL_RESET = 8'h00;
   localparam logic [7:0] LDN_RESET = 8'h00;
   localparam logic [7:0] PIN_MUX_RESET = 8'h00;
   localparam logic [7:0] INDEX_RESET = 8'h00;
   localparam logic [7:0] WDT_UNIT_RESET = 8'h00;
   localparam logic [7:0] WDT_COUNT_RESET = 8'h00;
   localparam logic [7:0] IDLE_READ = 8'hFF;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int CLK_HZ = 250_000_000;
   localparam int WDT_SECOND_S = 1;
   localparam int SECOND_CYCLES = WDT_SECOND_S * CLK_HZ;
   localparam int MINUTE_SECONDS = 60;
   localparam int CPU_RESET_NS = 1000;
   localparam int RESET_PULSE_CYCLES = (CPU_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ==========================================================
   // configuration lock sequence
   typedef enum logic [1:0] {LOCKED, KEY_ONCE, UNLOCKED} lock_state_t;
endpackage

// ---- test/config_space_asserts.sv ----
// concurrent checks on the configuration space ports
`timescale 1ns/100ps
`default_nettype none
module config_space_asserts
#(
   parameter int PINS = 8,
   parameter int SECOND_CYCLES = 20,
   parameter int RESET_CYCLES = 4
)
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic reset_in,
   // host i/o port access
   input wire logic [15:0] io_addr_in,
   input wire logic io_wr_in,
   input wire logic io_rd_in,
   input wire logic [7:0] io_wdata_in,
   input wire logic [7:0] io_rdata_out,
   input wire logic io_rvalid_out,
   input wire logic port_strap_in,
   // pins, watchdog and status
   input wire logic [PINS-1:0] gpio_pin_in,
   input wire logic [PINS-1:0] gpio_pin_out,
   input wire logic [PINS-1:0] gpio_pin_oe_out,
   input wire logic wdt_irq_mode_in,
   input wire logic cpu_reset_out,
   input wire logic wdt_irq_out,
   input wire logic config_unlocked_out
);
   // ==========================================================
   // decode helpers
   logic [15:0] idx_port;
   logic [15:0] dat_port;
   logic idx_wr;
   logic key_wr;
   logic lock_wr;
   int pulse_len;
   assign idx_port = port_strap_in ? cfg_pkg::INDEX_PORT_HI : cfg_pkg::INDEX_PORT_LO;
   assign dat_port = port_strap_in ? cfg_pkg::DATA_PORT_HI : cfg_pkg::DATA_PORT_LO;
   assign idx_wr = io_wr_in && (io_addr_in == idx_port);
   assign key_wr = idx_wr && (io_wdata_in == 8'h87);
   assign lock_wr = idx_wr && (io_wdata_in == 8'hAA);
   // counts a reset pulse, too long to unroll as a repetition
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
         pulse_len <= 0;
      else if (cpu_reset_out)
         pulse_len <= pulse_len + 1;
      else
         pulse_len <= 0;
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   a_read_answer: assert property (io_rd_in &&
      (io_addr_in == idx_port || io_addr_in == dat_port) |=> io_rvalid_out)
      else $error("decoded read not answered");
   a_index_write_only: assert property (io_rd_in && io_addr_in == idx_port
      |=> io_rdata_out == 8'hFF) else $error("index port read not FF");
   a_locked_read_ff: assert property (io_rd_in && io_addr_in == dat_port
      && !config_unlocked_out |=> io_rdata_out == 8'hFF) else $error("locked read not FF");
   a_unlock_cause: assert property ($rose(config_unlocked_out) |-> $past(key_wr))
      else $error("unlock without key write");
   a_lock_key: assert property (config_unlocked_out && lock_wr |=> !config_unlocked_out)
      else $error("lock key ignored");
   a_unlock_hold: assert property (config_unlocked_out && !idx_wr |=> config_unlocked_out)
      else $error("unlock dropped without index write");
   a_pins_by_write: assert property ($changed(gpio_pin_out) || $changed(gpio_pin_oe_out)
      |-> $past(io_wr_in, 2)) else $error("pins changed without a write");
   a_irq_hold: assert property (wdt_irq_out && !io_wr_in |=> wdt_irq_out)
      else $error("irq dropped without a write");
   a_irq_mode: assert property ($rose(wdt_irq_out) |-> $past(wdt_irq_mode_in))
      else $error("irq raised in reset mode");
   a_reset_mode: assert property ($rose(cpu_reset_out) |-> !$past(wdt_irq_mode_in))
      else $error("cpu reset raised in irq mode");
   a_reset_pulse: assert property ($fell(cpu_reset_out) |-> pulse_len == RESET_CYCLES)
      else $error("cpu reset pulse length wrong");
   cover property ($rose(config_unlocked_out));
   cover property ($rose(wdt_irq_out));
   cover property ($fell(cpu_reset_out));
endmodule
bind config_space config_space_asserts #(.PINS(PINS), .SECOND_CYCLES(SECOND_CYCLES),
   .RESET_CYCLES(RESET_CYCLES)) config_space_asserts_inst (.mclk_in, .reset_in, .io_addr_in,
   .io_wr_in, .io_rd_in, .io_wdata_in, .io_rdata_out, .io_rvalid_out, .port_strap_in,
   .gpio_pin_in, .gpio_pin_out, .gpio_pin_oe_out, .wdt_irq_mode_in, .cpu_reset_out,
   .wdt_irq_out, .config_unlocked_out);
`default_nettype wire

// ---- test/host_model.sv ----
// host processor model issuing i/o port reads and writes
`timescale 1ns/100ps
`default_nettype none
module host_model
(
   // clock
   input wire logic mclk_in,
   // i/o port bus
   output logic [15:0] io_addr_out,
   output logic io_wr_out,
   output logic io_rd_out,
   output logic [7:0] io_wdata_out,
   input wire logic [7:0] io_rdata_in,
   input wire logic io_rvalid_in
);
   // ==========================================================
   // bus cycles
   initial
   begin
      io_addr_out = 16'h0000;
      io_wr_out = 1'b0;
      io_rd_out = 1'b0;
      io_wdata_out = 8'h00;
   end
   // released lines carry the inverse so a stale value never looks valid
   task automatic io_write(input logic [15:0] a, input logic [7:0] d);
   begin
      @(posedge mclk_in);
      io_addr_out <= a;
      io_wdata_out <= d;
      io_wr_out <= 1'b1;
      @(posedge mclk_in);
      io_wr_out <= 1'b0;
      io_addr_out <= ~a;
      io_wdata_out <= ~d;
   end
   endtask
   // fixed latency: answer settles just after the edge that takes the strobe
   task automatic io_read(input logic [15:0] a, output logic [7:0] d, output logic ok);
   begin
      @(posedge mclk_in);
      io_addr_out <= a;
      io_rd_out <= 1'b1;
      @(posedge mclk_in);
      io_rd_out <= 1'b0;
      io_addr_out <= ~a;
      #1;
      ok = io_rvalid_in;
      d = io_rdata_in;
   end
   endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking testbench for the configuration space block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam int SEC = 20;
   localparam int RST = 4;
   logic mclk_in = 1'b0;
   logic reset_in = 1'b1;
   logic port_strap_in = 1'b1;
   logic wdt_irq_mode_in = 1'b1;
   logic [7:0] gpio_pin_in = 8'h3C;
   logic [15:0] io_addr_in;
   logic io_wr_in;
   logic io_rd_in;
   logic [7:0] io_wdata_in;
   logic [7:0] io_rdata_out;
   logic io_rvalid_out;
   logic [7:0] gpio_pin_out;
   logic [7:0] gpio_pin_oe_out;
   logic cpu_reset_out;
   logic wdt_irq_out;
   logic config_unlocked_out;
   logic [15:0] ip = cfg_pkg::INDEX_PORT_HI;
   logic [15:0] dp = cfg_pkg::DATA_PORT_HI;
   int num_errors = 0;
   int samples_checked = 0;
   always #2 mclk_in = ~mclk_in;
   config_space #(.SECOND_CYCLES(SEC), .RESET_CYCLES(RST)) config_space_inst
   (
      .mclk_in, .reset_in, .io_addr_in, .io_wr_in, .io_rd_in, .io_wdata_in, .io_rdata_out,
      .io_rvalid_out, .port_strap_in, .gpio_pin_in, .gpio_pin_out, .gpio_pin_oe_out,
      .wdt_irq_mode_in, .cpu_reset_out, .wdt_irq_out, .config_unlocked_out
   );
   host_model host_model_inst
   (
      .mclk_in, .io_addr_out(io_addr_in), .io_wr_out(io_wr_in), .io_rd_out(io_rd_in),
      .io_wdata_out(io_wdata_in), .io_rdata_in(io_rdata_out), .io_rvalid_in(io_rvalid_out)
   );
   // ==========================================================
   // helpers
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
   begin
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   end
   endtask
   task automatic put(input logic [7:0] idx, input logic [7:0] d);
   begin
      host_model_inst.io_write(ip, idx);
      host_model_inst.io_write(dp, d);
   end
   endtask
   task automatic get(input string what, input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
   begin
      host_model_inst.io_write(ip, idx);
      host_model_inst.io_read(dp, d, ok);
      check(what, 8'h01, {7'h00, ok});
      check(what, exp, d);
   end
   endtask
   task automatic unlock;
   begin
      host_model_inst.io_write(ip, 8'h87);
      host_model_inst.io_write(ip, 8'h87);
      #1;
   end
   endtask
   task automatic restart(input logic strap);
   begin
      @(posedge mclk_in);
      reset_in <= 1'b1;
      port_strap_in <= strap;
      repeat (3) @(posedge mclk_in);
      reset_in <= 1'b0;
      ip = strap ? cfg_pkg::INDEX_PORT_HI : cfg_pkg::INDEX_PORT_LO;
      dp = strap ? cfg_pkg::DATA_PORT_HI : cfg_pkg::DATA_PORT_LO;
      @(posedge mclk_in);
   end
   endtask
   // counts edges until the chosen watchdog output goes high, bounded
   task automatic edges_to_high(input logic pick_reset, output int n);
   begin
      n = 0;
      while ((pick_reset ? cpu_reset_out : wdt_irq_out) !== 1'b1 && n < 200)
      begin
         @(posedge mclk_in);
         #1;
         n++;
      end
   end
   endtask
   task automatic close_out;
   begin
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   // ==========================================================
   // tests
   initial
   begin
      logic [7:0] d;
      logic ok;
      int n;
      restart(1'b0);
      host_model_inst.io_write(16'h004E, 8'h87);
      host_model_inst.io_write(16'h004E, 8'h87);
      #1;
      check("unlock at other strap port", 8'h00, {7'h00, config_unlocked_out});
      unlock();
      check("unlock low ports", 8'h01, {7'h00, config_unlocked_out});
      get("device select reset", 8'h07, 8'h00);
      $display("test strap_low done");
      restart(1'b1);
      host_model_inst.io_read(ip, d, ok);
      check("index port read", 8'hFF, d);
      host_model_inst.io_read(dp, d, ok);
      check("locked data read", 8'hFF, d);
      host_model_inst.io_write(ip, 8'h87);
      host_model_inst.io_write(ip, 8'h07);
      #1;
      check("broken key", 8'h00, {7'h00, config_unlocked_out});
      unlock();
      check("unlocked", 8'h01, {7'h00, config_unlocked_out});
      put(8'h07, 8'h07);
      get("direction reset", 8'hF0, 8'hFF);
      get("input value", 8'hF1, 8'h3C);
      get("polarity reset", 8'hF2, 8'h00);
      get("undefined index", 8'h55, 8'h00);
      get("pin mux reset", 8'h2A, 8'h00);
      put(8'h2A, 8'h00 | 8'hFC);
      get("pin mux set", 8'h2A, 8'hFC);
      put(8'h30, 8'h01);
      put(8'hF0, 8'hF0);
      put(8'hF1, 8'hA5);
      get("mixed value", 8'hF1, 8'h35);
      host_model_inst.io_read(dp, d, ok);
      check("index kept", 8'h35, d);
      check("pin drive", 8'h05, gpio_pin_out);
      check("pin enable", 8'h0F, gpio_pin_oe_out);
      put(8'hF2, 8'hFF);
      get("inverted value", 8'hF1, 8'hC5);
      check("inverted drive", 8'hFA, gpio_pin_out);
      host_model_inst.io_write(ip, 8'hAA);
      host_model_inst.io_write(dp, 8'h00);
      #1;
      check("relocked", 8'h00, {7'h00, config_unlocked_out});
      unlock();
      get("write while locked", 8'hF1, 8'hC5);
      put(8'h30, 8'h00);
      @(posedge mclk_in);
      #1;
      check("port off", 8'h00, gpio_pin_oe_out);
      $display("test gpio done");
      put(8'h07, 8'h08);
      put(8'h30, 8'h01);
      put(8'hF5, 8'h00);
      put(8'hF6, 8'h03);
      edges_to_high(1'b0, n);
      check("irq delay", 8'(3 * SEC), n[7:0]);
      get("count expired", 8'hF6, 8'h00);
      check("irq held", 8'h01, {7'h00, wdt_irq_out});
      @(posedge mclk_in);
      wdt_irq_mode_in <= 1'b0;
      put(8'hF6, 8'h01);
      #1;
      check("irq cleared", 8'h00, {7'h00, wdt_irq_out});
      edges_to_high(1'b1, n);
      check("reset delay", 8'(SEC), n[7:0]);
      n = 0;
      while (cpu_reset_out === 1'b1 && n < 20)
      begin
         n++;
         @(posedge mclk_in);
         #1;
      end
      check("reset length", 8'(RST), n[7:0]);
      $display("test watchdog done");
      close_out();
   end
   initial
   begin
      repeat (20000) @(posedge mclk_in);
      num_errors++;
      $display("timeout waiting for the tests");
      close_out();
   end
endmodule
`default_nettype wire
